// ---- design/ssd_defines.vh ----
// Overview of operation
// - Shift one passes all 4096 channels unchanged.
// - Shift two: five-tap window, step two, 2046 outputs.
// - Shift three: seven-tap window, step three, 1364 outputs.
// - Shift four: nine-tap window, step four, 1022 outputs.
// - Smoothing codes 0-3 select shifts 1-4, default 0.
// - Integration codes 0-3 mean 30-120 s, default 30.
// - Power codes 1-6 decoded, default engineering.
// - Spectroscopic modes emit sum-of-squares midpoints as diagnostics.
// - Midpoint near 125 healthy; zero means spectrometer fault.
// - Mode changes start only outside calibration.
// - Single pending slot; newest command overwrites older.
// - In spectroscopic modes one full integration completes before switching; other modes switch at once.
`ifndef SSD_DEFINES_VH
`define SSD_DEFINES_VH

// Register byte offsets.
`define SSD_REG_CTRL 8'h00
`define SSD_REG_STATUS 8'h04
`define SSD_REG_IRQ_STAT 8'h08
`define SSD_REG_IRQ_MASK 8'h0c
`define SSD_REG_INFO 8'h10

// Control and status field positions.
`define SSD_F_SMOOTH 1:0
`define SSD_F_INTEG 3:2
`define SSD_F_POWER 6:4
`define SSD_B_PENDING 7
`define SSD_B_CALIB 8
`define SSD_F_STATE 10:9
`define SSD_F_SECONDS 6:0
`define SSD_F_HEALTH 11:8

// Interrupt bits.
`define SSD_IRQ_W 4
`define SSD_I_SPEC_DONE 0
`define SSD_I_APPLIED 1
`define SSD_I_SOS_FAULT 2
`define SSD_I_BAD_CMD 3

// Smoothing codes.
`define SSD_SM1 2'h0
`define SSD_SM2 2'h1
`define SSD_SM3 2'h2
`define SSD_SM4 2'h3

// Integration codes and their seconds.
`define SSD_INT_30 2'h0
`define SSD_INT_60 2'h1
`define SSD_INT_90 2'h2
`define SSD_INT_120 2'h3
`define SSD_SEC_30 7'h1e
`define SSD_SEC_60 7'h3c
`define SSD_SEC_90 7'h5a
`define SSD_SEC_120 7'h78

// Power mode codes.
`define SSD_PM_SPEC_DUAL 3'h1
`define SSD_PM_SPEC_SMM 3'h2
`define SSD_PM_DUAL 3'h3
`define SSD_PM_SMM 3'h4
`define SSD_PM_MM 3'h5
`define SSD_PM_ENG 3'h6

// Weights in units of 1/4096.
`define SSD_WQ 12
`define SSD_W_ROUND 13'h0800
`define SSD_W_UNITY 13'h1000
`define SSD_W_01 13'h0029
`define SSD_W_03 13'h007b
`define SSD_W_11 13'h01c3
`define SSD_W_22 13'h0385
`define SSD_W_23 13'h03ae
`define SSD_W_24 13'h03d7
`define SSD_W_30 13'h04cd
`define SSD_W_32 13'h051f
`define SSD_W_50 13'h0800

// Sum-of-squares midpoint health.
`define SSD_SOS_NOMINAL 16'h007d
`define SSD_SOS_TOL 16'h0019

// Mode change states.
`define SSD_ST_NOMINAL 2'h0
`define SSD_ST_WAIT_START 2'h1
`define SSD_ST_WAIT_END 2'h2
`define SSD_ST_APPLY 2'h3

`endif

// ---- design/ssd_sync.v ----
`timescale 1ns/1ns
`default_nettype none
module ssd_sync (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Raw pin and settled level
	input wire pin,
	output reg level
);
	reg s1;
	reg s2;
	reg s3;

	// The level moves only when the second and third stages agree.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule // ssd_sync
`default_nettype wire

// ---- design/ssd_coef.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ssd_defines.vh"
module ssd_coef #(
	parameter TAP = 0
) (
	// Smoothing code
	input wire [1:0] code,
	// Weight of this tap
	output reg [12:0] weight
);
	always @* begin
		weight = 13'h0;
		case (code)
		`SSD_SM1: begin
			if (TAP == 0) weight = `SSD_W_UNITY;
		end
		`SSD_SM2: begin
			case (TAP)
			0, 4: weight = `SSD_W_03;
			1, 3: weight = `SSD_W_22;
			2: weight = `SSD_W_50;
			default: weight = 13'h0;
			endcase
		end
		`SSD_SM3: begin
			case (TAP)
			0, 6: weight = `SSD_W_01;
			1, 5: weight = `SSD_W_03;
			2, 4: weight = `SSD_W_30;
			3: weight = `SSD_W_32;
			default: weight = 13'h0;
			endcase
		end
		default: begin
			case (TAP)
			0, 8: weight = `SSD_W_01;
			1, 7: weight = `SSD_W_03;
			2, 6: weight = `SSD_W_11;
			3, 5: weight = `SSD_W_23;
			4: weight = `SSD_W_24;
			default: weight = 13'h0;
			endcase
		end
		endcase
	end
endmodule // ssd_coef
`default_nettype wire

// ---- design/ssd_smoother.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ssd_defines.vh"
module ssd_smoother #(
	parameter DATA_W = 16,
	parameter CHANNELS = 4096
) (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Wishbone slave
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [7:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatI,
	output reg [31:0] wbDatO,
	output reg wbAck,
	// Calibration in progress, from a pin
	input wire calPin,
	// Spectrum input
	input wire inValid,
	input wire inFirst,
	input wire [DATA_W-1:0] inData,
	// Smoothed spectrum output
	output reg outValid,
	output reg outLast,
	output reg [11:0] outIndex,
	output reg [DATA_W-1:0] outData,
	// Sum-of-squares midpoints in and diagnostics out
	input wire sosValid,
	input wire [1:0] sosIdx,
	input wire [DATA_W-1:0] sosMid,
	output reg miscValid,
	output reg [1:0] miscIdx,
	output reg [DATA_W-1:0] miscData,
	// Interrupt
	output reg irq
);
	localparam PW = DATA_W + 13;
	localparam SW = PW + 4;
	localparam integer LASTNUM = CHANNELS - 1;
	localparam [12:0] LASTCH = LASTNUM[12:0];
	localparam [SW-1:0] MAXOUT = {{(SW-DATA_W){1'b0}}, {DATA_W{1'b1}}};

	wire calib;
	reg [1:0] actSmooth;
	reg [1:0] actInteg;
	reg [2:0] actPower;
	reg [1:0] pendSmooth;
	reg [1:0] pendInteg;
	reg [2:0] pendPower;
	reg pending;
	reg [1:0] state;
	reg [`SSD_IRQ_W-1:0] irqStat;
	reg [`SSD_IRQ_W-1:0] irqMask;
	reg [3:0] health;
	reg [6:0] seconds;
	reg [12:0] chanCnt;
	reg [2:0] phase;
	reg [DATA_W-1:0] taps [0:8];
	reg fire;
	reg fireFirst;
	reg fireLast;
	reg [`SSD_IRQ_W-1:0] events;

	ssd_sync calSync (
		.clk(ref_clk),
		.nrst(nrst),
		.pin(calPin),
		.level(calib)
	);

	// Bus decode.
	wire wbReq = wbCyc & wbStb & ~wbAck;
	wire wbWr = wbReq & wbWe & wbSel[0];
	wire ctrlWr = wbWr & (wbAdr == `SSD_REG_CTRL);
	wire [2:0] newPower = wbDatI[`SSD_F_POWER];
	wire powerOk = (newPower >= `SSD_PM_SPEC_DUAL) &&
		(newPower <= `SSD_PM_ENG);
	wire cmdTake = ctrlWr & powerOk;
	wire spectro = (actPower == `SSD_PM_SPEC_DUAL) ||
		(actPower == `SSD_PM_SPEC_SMM);

	// Window geometry for the active smoothing code.
	wire [2:0] shift = {1'b0, actSmooth} + 3'h1;
	wire [3:0] winLast = (actSmooth == `SSD_SM1) ? 4'h0 :
		{shift, 1'b0};
	wire [12:0] chan = inFirst ? 13'h0 : chanCnt;
	wire atFirstWin = chan == {9'h0, winLast};
	wire [2:0] curPhase = atFirstWin ? 3'h0 : phase;
	wire [2:0] phaseInc = curPhase + 3'h1;
	wire takeWin = (chan >= {9'h0, winLast}) &&
		(curPhase == 3'h0);
	wire specEnd = inValid && (chan == LASTCH);

	// Sample window and per-channel bookkeeping.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			chanCnt <= 13'h0;
			phase <= 3'h0;
			fire <= 1'b0;
			fireFirst <= 1'b0;
			fireLast <= 1'b0;
		end else begin
			fire <= inValid & takeWin;
			if (inValid) begin
				chanCnt <= chan + 13'h1;
				phase <= (phaseInc == shift) ? 3'h0 : phaseInc;
				fireFirst <= atFirstWin;
				fireLast <= (chan + {10'h0, shift}) > LASTCH;
			end
		end
	end

	// Cleared so that a zero weight never meets an undefined tap value.
	integer k;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (k = 0; k < 9; k = k + 1) begin
				taps[k] <= {DATA_W{1'b0}};
			end
		end else if (inValid) begin
			taps[0] <= inData;
			for (k = 1; k < 9; k = k + 1) begin
				taps[k] <= taps[k-1];
			end
		end
	end

	// Weighted sum over the nine taps; unused taps weigh zero.
	wire [SW-1:0] part [0:9];
	assign part[0] = {SW{1'b0}};
	genvar g;
	generate
		for (g = 0; g < 9; g = g + 1) begin : gTap
			wire [12:0] w;
			wire [PW-1:0] prod;
			ssd_coef #(.TAP(g)) coef (
				.code(actSmooth),
				.weight(w)
			);
			assign prod = taps[g] * w;
			assign part[g+1] = part[g] + {4'h0, prod};
		end
	endgenerate

	// Round to nearest, then clip in case the rounded weights overshoot.
	wire [SW-1:0] rounded = (part[9] + {{(SW-13){1'b0}},
		`SSD_W_ROUND}) >> `SSD_WQ;
	wire [DATA_W-1:0] clipped = (rounded > MAXOUT) ? {DATA_W{1'b1}} :
		rounded[DATA_W-1:0];

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			outValid <= 1'b0;
			outLast <= 1'b0;
			outIndex <= 12'h0;
			outData <= {DATA_W{1'b0}};
		end else begin
			outValid <= fire;
			if (fire) begin
				outData <= clipped;
				outLast <= fireLast;
				outIndex <= fireFirst ? 12'h0 : outIndex + 12'h1;
			end
		end
	end

	// Diagnostics from the sum-of-squares tables.
	wire sosTake = sosValid & spectro;
	wire sosZero = sosMid == {DATA_W{1'b0}};
	wire sosGood = (sosMid >= `SSD_SOS_NOMINAL - `SSD_SOS_TOL) &&
		(sosMid <= `SSD_SOS_NOMINAL + `SSD_SOS_TOL);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			miscValid <= 1'b0;
			miscIdx <= 2'h0;
			miscData <= {DATA_W{1'b0}};
			health <= 4'h0;
		end else begin
			miscValid <= sosTake;
			if (sosTake) begin
				miscIdx <= sosIdx;
				miscData <= sosMid;
				health[sosIdx] <= sosGood & ~sosZero;
			end
		end
	end

	// Mode change sequencing.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= `SSD_ST_NOMINAL;
			actSmooth <= `SSD_SM1;
			actInteg <= `SSD_INT_30;
			actPower <= `SSD_PM_ENG;
			pendSmooth <= `SSD_SM1;
			pendInteg <= `SSD_INT_30;
			pendPower <= `SSD_PM_ENG;
			pending <= 1'b0;
		end else begin
			if (cmdTake) begin
				pendSmooth <= wbDatI[`SSD_F_SMOOTH];
				pendInteg <= wbDatI[`SSD_F_INTEG];
				pendPower <= newPower;
			end
			case (state)
			`SSD_ST_NOMINAL: begin
				if (pending && !calib) begin
					// Without a spectrometer running there is nothing to drain.
					state <= spectro ? `SSD_ST_WAIT_START :
						`SSD_ST_APPLY;
				end
			end
			`SSD_ST_WAIT_START: begin
				if (inValid && inFirst) state <= `SSD_ST_WAIT_END;
			end
			`SSD_ST_WAIT_END: begin
				if (specEnd) state <= `SSD_ST_APPLY;
			end
			`SSD_ST_APPLY: begin
				actSmooth <= pendSmooth;
				actInteg <= pendInteg;
				actPower <= pendPower;
				state <= `SSD_ST_NOMINAL;
			end
			default: state <= `SSD_ST_NOMINAL;
			endcase
			if (cmdTake) begin
				pending <= 1'b1;
			end else if (state == `SSD_ST_APPLY) begin
				pending <= 1'b0;
			end
		end
	end

	// Seconds of the active integration period.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			seconds <= `SSD_SEC_30;
		end else begin
			case (actInteg)
			`SSD_INT_30: seconds <= `SSD_SEC_30;
			`SSD_INT_60: seconds <= `SSD_SEC_60;
			`SSD_INT_90: seconds <= `SSD_SEC_90;
			default: seconds <= `SSD_SEC_120;
			endcase
		end
	end

	// Interrupt sources.
	always @* begin
		events = {`SSD_IRQ_W{1'b0}};
		events[`SSD_I_SPEC_DONE] = specEnd;
		events[`SSD_I_APPLIED] = state == `SSD_ST_APPLY;
		events[`SSD_I_SOS_FAULT] = sosTake & sosZero;
		events[`SSD_I_BAD_CMD] = ctrlWr & ~powerOk;
	end

	wire irqClrWr = wbWr && (wbAdr == `SSD_REG_IRQ_STAT);
	wire [`SSD_IRQ_W-1:0] clr = irqClrWr ?
		wbDatI[`SSD_IRQ_W-1:0] : {`SSD_IRQ_W{1'b0}};
	wire [`SSD_IRQ_W-1:0] next_irqStat = (irqStat & ~clr) | events;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irqStat <= {`SSD_IRQ_W{1'b0}};
			irqMask <= {`SSD_IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			// A new event in the clearing cycle stays set.
			irqStat <= next_irqStat;
			if (wbWr && (wbAdr == `SSD_REG_IRQ_MASK)) begin
				irqMask <= wbDatI[`SSD_IRQ_W-1:0];
			end
			irq <= |(next_irqStat & irqMask);
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge.
	reg [31:0] rdData;
	always @* begin
		rdData = 32'h0;
		case (wbAdr)
		`SSD_REG_CTRL: begin
			rdData[`SSD_F_SMOOTH] = pendSmooth;
			rdData[`SSD_F_INTEG] = pendInteg;
			rdData[`SSD_F_POWER] = pendPower;
		end
		`SSD_REG_STATUS: begin
			rdData[`SSD_F_SMOOTH] = actSmooth;
			rdData[`SSD_F_INTEG] = actInteg;
			rdData[`SSD_F_POWER] = actPower;
			rdData[`SSD_B_PENDING] = pending;
			rdData[`SSD_B_CALIB] = calib;
			rdData[`SSD_F_STATE] = state;
		end
		`SSD_REG_IRQ_STAT: rdData[`SSD_IRQ_W-1:0] = irqStat;
		`SSD_REG_IRQ_MASK: rdData[`SSD_IRQ_W-1:0] = irqMask;
		`SSD_REG_INFO: begin
			rdData[`SSD_F_SECONDS] = seconds;
			rdData[`SSD_F_HEALTH] = health;
		end
		default: rdData = 32'h0;
		endcase
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wbAck <= 1'b0;
			wbDatO <= 32'h0;
		end else begin
			wbAck <= wbReq;
			if (wbReq) wbDatO <= rdData;
		end
	end
endmodule // ssd_smoother
`default_nettype wire

// ---- bench/ssd_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssd_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Bus
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbAck,
	// Streams
	input wire logic inValid,
	input wire logic outValid,
	input wire logic outLast,
	input wire logic [11:0] outIndex,
	input wire logic sosValid,
	input wire logic [15:0] sosMid,
	input wire logic miscValid,
	input wire logic [15:0] miscData,
	input wire logic irq
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	logic [11:0] expIdx;
	// A spectrum always restarts its numbering at zero.
	always @(posedge ref_clk or negedge nrst)
		if (!nrst)
			expIdx <= 12'h000;
		else if (outValid)
			expIdx <= outLast ? 12'h000 : outIndex + 12'h001;
	AST_ACK_ONE:
	assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("ack late");
	AST_ACK_PULSE:
	assert property (wbAck |=> !wbAck) else $error("ack too long");
	AST_ACK_REQ:
	assert property (wbAck |-> $past(wbCyc && wbStb)) else $error("stray ack");
	AST_OUT_LAT:
	assert property (outValid |-> $past(inValid, 2)) else $error("no sample");
	AST_LAST_IDX:
	assert property (outValid && outLast |-> outIndex inside
		{12'hfff, 12'h7fd, 12'h553, 12'h3fd}) else $error("bad count");
	AST_IDX_STEP:
	assert property (outValid |-> outIndex == expIdx) else $error("bad order");
	AST_MISC:
	assert property (miscValid |-> $past(sosValid) && miscData == $past(sosMid))
		else $error("bad midpoint copy");
	AST_RST_QUIET:
	assert property ($rose(nrst) |-> !outValid && !wbAck && !irq && !miscValid)
		else $error("output after reset");
endmodule // ssd_chk
bind ssd_smoother ssd_chk CHK (.ref_clk, .nrst, .wbCyc, .wbStb, .wbAck,
	.inValid, .outValid, .outLast, .outIndex, .sosValid, .sosMid,
	.miscValid, .miscData, .irq);
`default_nettype wire

// ---- bench/ssd_backend.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssd_backend (
	// Control from the bench
	input wire logic ref_clk,
	input wire logic go,
	input wire logic slow,
	input wire logic [15:0] mid,
	input wire logic [15:0] spec [4096],
	output logic busy,
	// Spectrum and midpoint stream
	output logic inValid,
	output logic inFirst,
	output logic [15:0] inData,
	output logic sosValid,
	output logic [1:0] sosIdx,
	output logic [15:0] sosMid
);
	int c;
	logic gap;
	// Idle data lines carry inverted values so stale data never looks valid.
	initial begin
		{busy, inValid, inFirst, sosValid, sosIdx} = '0;
		inData = 16'h5a5a;
		sosMid = 16'ha5a5;
		forever begin
			@(posedge ref_clk);
			if (go) begin
				busy <= 1;
				c = 0;
				gap = 0;
				while (c < 4096) begin
					if (slow && gap) begin
						inValid <= 0;
						inData <= ~inData;
					end else begin
						inValid <= 1;
						inFirst <= c == 0;
						inData <= spec[c];
						c++;
					end
					gap = ~gap;
					@(posedge ref_clk);
				end
				inValid <= 0;
				inData <= ~inData;
				for (int i = 0; i < 4; i++) begin
					sosValid <= 1;
					sosIdx <= 2'(i);
					sosMid <= mid;
					@(posedge ref_clk);
				end
				sosValid <= 0;
				sosMid <= ~mid;
				busy <= 0;
			end
		end
	end
endmodule // ssd_backend
`default_nettype wire

// ---- bench/spectrum_smoothing_decimator_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module spectrum_smoothing_decimator_bench;
	logic ref_clk = 0, nrst = 0, calPin = 0, go = 0, slow = 0;
	logic wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, outValid, outLast, irq;
	logic inValid, inFirst, sosValid, miscValid, busy;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatI = 32'h0, wbDatO, rd, d;
	logic [11:0] outIndex;
	logic [15:0] inData, outData, sosMid, miscData, mid = 16'h007d;
	logic [15:0] lfsr = 16'h38de;
	logic [15:0] spec [4096];
	logic [1:0] sosIdx, miscIdx;
	int miscompares = 0, checkCount = 0, curS = 1, k = 0, nMisc = 0;
	int nOut [4] = '{4096, 2046, 1364, 1022};
	// Weights in 1/4096; shift one passes samples straight through.
	int wt [3][9] = '{'{123, 901, 2048, 901, 123, 0, 0, 0, 0},
		'{41, 123, 1229, 1311, 1229, 123, 41, 0, 0},
		'{41, 123, 451, 942, 983, 942, 451, 123, 41}};
	always #10 ref_clk = ~ref_clk;
	ssd_smoother DUT (.ref_clk, .nrst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
		.wbDatI, .wbDatO, .wbAck, .calPin, .inValid, .inFirst, .inData,
		.outValid, .outLast, .outIndex, .outData, .sosValid, .sosIdx, .sosMid,
		.miscValid, .miscIdx, .miscData, .irq);
	ssd_backend FAR (.ref_clk, .go, .slow, .mid, .spec, .busy, .inValid,
		.inFirst, .inData, .sosValid, .sosIdx, .sosMid);
	function logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function logic [31:0] expd(input int n);
		int acc;
		acc = 2048;
		if (curS == 1)
			return spec[n];
		for (int j = 0; j <= 2 * curS; j++)
			acc += wt[curS - 2][j] * spec[n * curS + j];
		acc = acc >> 12;
		return acc > 65535 ? 65535 : acc;
	endfunction
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// The answer is awaited as long as it takes; only the watchdog ends a hang.
	task wb(input logic we, input logic [7:0] a, input logic [31:0] v);
		repeat (3) @(posedge ref_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'h3, we, a, 4'hf, v};
		do @(posedge ref_clk); while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 0;
		wbStb <= 0;
	endtask
	task spectrum(input int s, input logic sl);
		curS = s;
		for (int i = 0; i < 4096; i++) begin
			spec[i] = i < 9 ? 16'hffff : lfsr;
			lfsr = nxt(lfsr);
		end
		slow <= sl;
		go <= 1;
		@(posedge ref_clk);
		go <= 0;
		do @(posedge ref_clk); while (busy !== 1'b0);
		$display("spectrum shift %0d done", s);
	endtask
	task summarize;
		$display("checks %0d miscompares %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (nrst && outValid === 1'b1) begin
			cmp(outIndex, k);
			cmp(outData, expd(k));
			if (outLast === 1'b1) begin
				cmp(k + 1, nOut[curS - 1]);
				k = 0;
			end else
				k++;
		end
		if (nrst && miscValid === 1'b1) begin
			cmp(miscIdx, nMisc % 4);
			nMisc++;
			cmp(miscData, mid);
		end
	end
	initial begin
		#1800000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1;
		wb(0, 8'h04, 0);
		cmp(rd[10:0], 11'h060);
		wb(0, 8'h10, 0);
		cmp(rd[6:0], 7'h1e);
		wb(0, 8'h14, 0);
		cmp(rd, 32'h0);
		wb(1, 8'h0c, 32'hf);
		// The illegal code goes first so its flag is the only one raised.
		for (int p = 7; p > 2; p--) begin
			wb(1, 8'h00, 32'(p) << 4);
			wb(0, 8'h04, 0);
			cmp(rd[6:4], p == 7 ? 6 : p);
			if (p == 7) begin
				wb(0, 8'h08, 0);
				cmp({irq, rd[3:0]}, 5'h18);
			end
		end
		wb(1, 8'h08, 32'hf);
		$display("power codes done");
		calPin <= 1;
		repeat (6) @(posedge ref_clk);
		wb(1, 8'h00, 32'h50);
		wb(1, 8'h00, 32'h40);
		wb(0, 8'h04, 0);
		cmp(rd[8:4], 5'h1b);
		calPin <= 0;
		repeat (6) @(posedge ref_clk);
		wb(0, 8'h04, 0);
		cmp(rd[8:4], 5'h04);
		$display("calibration done");
		for (int c = 0; c < 4; c++) begin
			d = {25'h0, 3'(c % 2 + 1), 2'(c), 2'(c)};
			wb(1, 8'h00, d);
			if (c > 0) begin
				wb(0, 8'h04, 0);
				cmp({rd[7], rd[1:0]}, 3 + c);
				spectrum(c, c[0]);
			end
			wb(0, 8'h04, 0);
			cmp(rd[7:0], d[7:0]);
			wb(0, 8'h10, 0);
			cmp(rd[6:0], 30 * (c + 1));
			spectrum(c + 1, c[1]);
		end
		wb(0, 8'h10, 0);
		cmp(rd[11:8], 4'hf);
		mid = 16'h0000;
		wb(1, 8'h08, 32'hf);
		spectrum(4, 0);
		wb(0, 8'h10, 0);
		cmp(rd[11:8], 4'h0);
		wb(0, 8'h08, 0);
		cmp({irq, rd[3:0]}, 5'h15);
		wb(1, 8'h0c, 32'h0);
		wb(0, 8'h08, 0);
		cmp({irq, rd[3:0]}, 5'h05);
		wb(1, 8'h08, 32'hf);
		wb(0, 8'h08, 0);
		cmp(rd[3:0], 4'h0);
		cmp(nMisc, 32);
		$display("health and interrupts done");
		summarize();
	end
endmodule // spectrum_smoothing_decimator_bench
`default_nettype wire
